// File: rtl/pafs_pkg.sv
package pafs_pkg;

  // pin group layout, index into the pin vectors
  localparam int NPIN       = 45;
  localparam int NSEG       = 35;
  localparam int NCOM       = 8;
  localparam int NSEGEN     = 31;
  localparam int PIN_P10_0  = 0;
  localparam int PIN_P9_3   = 1;
  localparam int PIN_P9_4   = 2;
  localparam int PIN_P9_5   = 3;
  localparam int PIN_P9_6   = 4;
  localparam int PIN_P9_7   = 5;
  localparam int PIN_P3_0   = 6;
  localparam int PIN_P4_0   = 10;
  localparam int PIN_P4_2   = 12;
  localparam int PIN_P4_7   = 17;
  localparam int PIN_P5_0   = 18;
  localparam int PIN_P5_2   = 20;
  localparam int PIN_P8_2   = 44;
  // segment line number = pin index - SEG_OFS
  localparam int SEG_OFS    = 10;
  // segment enable bit = pin index - SEGEN_OFS_LO / _HI
  localparam int SEGEN_OFS_LO = 12;
  localparam int SEGEN_OFS_HI = 14;
  localparam int COM_P4_BASE  = 4;
  localparam int COM_P5_BASE  = 6;
  localparam int SEG_P5_BASE  = 8;
  localparam int P3_COM_LINES = 4;
  localparam int PAIR_LINES   = 2;

  // register indexes; byte address is four times the index
  localparam logic [15:0] IDX_UART_CFG   = 16'h2A05;
  localparam logic [15:0] IDX_LCD_CTRL   = 16'h2C1E;
  localparam logic [15:0] IDX_P9SEL      = 16'h00AD;
  localparam logic [15:0] IDX_SEG_EN     = 16'h2C40;
  localparam logic [15:0] IDX_LCD_PIN_EN = 16'h2C41;
  localparam logic [15:0] IDX_MISC       = 16'h2C42;
  localparam logic [15:0] IDX_STATUS     = 16'h2C43;

  // field positions
  localparam int UART_EN_BIT   = 0;
  localparam int LCD_TYPE_LO   = 4;
  localparam int P9SEL_PWM_BIT = 7;
  localparam int P9SEL_ONE_BIT = 6;
  localparam int P9SEL_TWO_BIT = 5;
  localparam int P9SEL_PPS_BIT = 4;
  localparam int P9SEL_PLL_BIT = 3;
  localparam int LCDPIN_P3_BIT = 0;
  localparam int LCDPIN_P4_BIT = 1;
  localparam int LCDPIN_P5_BIT = 2;
  localparam int MISC_PLL1S_BIT = 0;
  localparam int MISC_PPSCAL_BIT = 1;
  localparam logic [1:0] LCD_COM_P4_MIN = 2'h1;
  localparam logic [1:0] LCD_COM_P5_MIN = 2'h2;

  // values after reset
  localparam logic [7:0]  RESET_REG8   = 8'h00;
  localparam logic [30:0] RESET_SEGEN  = 31'h0000_0000;
  localparam logic [2:0]  RESET_LCDPIN = 3'h0;
  localparam logic [1:0]  RESET_MISC   = 2'h0;

  // pulse-per-second calibration window
  localparam int          PPS_WINDOW_SECONDS = 30;
  localparam logic [4:0]  PPS_LAST_SECOND    = 5'(PPS_WINDOW_SECONDS - 1);

  typedef enum logic [0:0] {
    PAFS_BUS_IDLE = 1'b0,
    PAFS_BUS_WAIT = 1'b1
  } pafs_bus_e;

  typedef enum logic [2:0] {
    PAFS_SEL_NONE   = 3'b000,
    PAFS_SEL_UART   = 3'b001,
    PAFS_SEL_LCD    = 3'b010,
    PAFS_SEL_P9SEL  = 3'b011,
    PAFS_SEL_SEGEN  = 3'b100,
    PAFS_SEL_LCDPIN = 3'b101,
    PAFS_SEL_MISC   = 3'b110,
    PAFS_SEL_STATUS = 3'b111
  } pafs_sel_e;

  // register decode from a byte address
  function automatic pafs_sel_e pafs_decode(input logic [31:0] a);
    pafs_sel_e s;
    s = PAFS_SEL_NONE;
    if (a[1:0] == 2'h0 && a[31:18] == 14'h0000)
    begin
      unique case (a[17:2])
        IDX_UART_CFG:   s = PAFS_SEL_UART;
        IDX_LCD_CTRL:   s = PAFS_SEL_LCD;
        IDX_P9SEL:      s = PAFS_SEL_P9SEL;
        IDX_SEG_EN:     s = PAFS_SEL_SEGEN;
        IDX_LCD_PIN_EN: s = PAFS_SEL_LCDPIN;
        IDX_MISC:       s = PAFS_SEL_MISC;
        IDX_STATUS:     s = PAFS_SEL_STATUS;
        default:        s = PAFS_SEL_NONE;
      endcase
    end
    return s;
  endfunction

  // lcd type puts the pin pair on a backplane line
  function automatic logic pafs_is_com(input logic [1:0] t,
                                       input logic [1:0] lo);
    return t >= lo;
  endfunction

  typedef struct packed {
    logic [NPIN-1:0] stage1;
    logic [NPIN-1:0] stage2;
  } pafs_sync_s;

  typedef struct packed {
    logic [4:0] second;
    logic       pulse;
  } pafs_pps_s;

  typedef struct packed {
    pafs_bus_e       phase;
    logic [31:0]     addr;
    logic            write;
    logic            hreadyout;
    logic [31:0]     hrdata;
    logic            hresp;
    logic [7:0]      uart_cfg;
    logic [7:0]      lcd_ctrl;
    logic [7:0]      p9sel;
    logic [30:0]     seg_en;
    logic [2:0]      lcd_pin_en;
    logic [1:0]      misc;
    logic            pll_level;
    logic [NPIN-1:0] pin_out;
    logic [NPIN-1:0] pin_oe;
    logic            path_one_out;
  } pafs_top_s;

endpackage

// File: rtl/pafs_sync.sv
`timescale 1ns/1ns
module pafs_sync
  import pafs_pkg::*;
(
  input  wire logic            clk_in,
  input  wire logic            reset_n_in,
  input  wire logic [NPIN-1:0] pin_in,
  output logic      [NPIN-1:0] level_out
);

  pafs_sync_s cur;
  pafs_sync_s next_cur;

  // two-stage chain, only stage2 is read
  always_comb
  begin
    next_cur        = cur;
    next_cur.stage1 = pin_in;
    next_cur.stage2 = cur.stage1;
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      cur <= '0;
    else
      cur <= next_cur;
  end

  assign level_out = cur.stage2;

endmodule // pafs_sync

// File: rtl/pafs_pps_select.sv
`timescale 1ns/1ns
module pafs_pps_select
  import pafs_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       cal_enable_in,
  input  wire logic       uncal_pulse_in,
  input  wire logic       cal_pulse_in,
  output logic            pulse_out,
  output logic [4:0]      second_out
);

  pafs_pps_s cur;
  pafs_pps_s next_cur;

  // seconds 1..29 pass raw pulses, 30th passes calibrated one
  always_comb
  begin
    next_cur       = cur;
    next_cur.pulse = 1'b0;
    if (!cal_enable_in)
    begin
      next_cur.second = 5'h00;
      next_cur.pulse  = uncal_pulse_in;
    end
    else if (cur.second == PPS_LAST_SECOND)
    begin
      if (cal_pulse_in)
      begin
        next_cur.pulse  = 1'b1;
        next_cur.second = 5'h00;
      end
    end
    else if (uncal_pulse_in)
    begin
      next_cur.pulse  = 1'b1;
      next_cur.second = cur.second + 5'h01;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      cur <= '0;
    else
      cur <= next_cur;
  end

  assign pulse_out  = cur.pulse;
  assign second_out = cur.second;

endmodule // pafs_pps_select

// File: rtl/pafs_top.sv
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ns
module pafs_top
  import pafs_pkg::*;
(
  input  wire logic            clk_in,
  input  wire logic            reset_n_in,
  // ahb-lite slave
  input  wire logic            hsel_in,
  input  wire logic [31:0]     haddr_in,
  input  wire logic [1:0]      htrans_in,
  input  wire logic            hwrite_in,
  input  wire logic [2:0]      hsize_in,
  input  wire logic [31:0]     hwdata_in,
  input  wire logic            hready_in,
  output logic                 hreadyout_out,
  output logic      [31:0]     hrdata_out,
  output logic                 hresp_out,
  // general-purpose port logic
  input  wire logic [NPIN-1:0] gpio_out_in,
  input  wire logic [NPIN-1:0] gpio_oe_in,
  output logic      [NPIN-1:0] pin_level_out,
  // alternate function sources
  input  wire logic            enhanced_serial_port_one_data_line_tx_in,
  input  wire logic            enhanced_serial_port_one_data_line_oe_in,
  output logic                 enhanced_serial_port_one_data_line_rx_out,
  input  wire logic            card_clock_pulse_in,
  input  wire logic            energy_pulse_path_one_in,
  input  wire logic            energy_pulse_path_two_in,
  input  wire logic            pps_uncal_pulse_in,
  input  wire logic            pps_cal_pulse_in,
  input  wire logic            divided_pll_pulse_in,
  input  wire logic            pll_second_tick_in,
  input  wire logic [NCOM-1:0] lcd_backplane_lines_in,
  input  wire logic [NSEG-1:0] lcd_segment_line_in,
  // configuration seen by the engines
  output logic      [7:0]      enhanced_serial_one_config_out,
  output logic      [7:0]      lcd_control_reg_out,
  // pins
  input  wire logic [NPIN-1:0] pin_in,
  output logic      [NPIN-1:0] pin_out,
  output logic      [NPIN-1:0] pin_oe_out,
  output logic                 energy_pulse_path_one_out
);

  // registered state and its next value
  pafs_top_s   cur;
  pafs_top_s   next_cur;
  // helper signals from the sub-blocks and decoders
  logic [NPIN-1:0] pin_level;
  logic        pps_pulse;
  logic [4:0]  pps_second;
  logic [1:0]  lcd_type_field;
  pafs_sel_e   sel;

  // pin inputs into the clock domain
  pafs_sync u_sync (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .pin_in     (pin_in),
    .level_out  (pin_level)
  );

  // calibrated pulse-per-second pattern
  pafs_pps_select u_pps (
    .clk_in         (clk_in),
    .reset_n_in     (reset_n_in),
    .cal_enable_in  (cur.misc[MISC_PPSCAL_BIT]),
    .uncal_pulse_in (pps_uncal_pulse_in),
    .cal_pulse_in   (pps_cal_pulse_in),
    .pulse_out      (pps_pulse),
    .second_out     (pps_second)
  );

  assign lcd_type_field = cur.lcd_ctrl[LCD_TYPE_LO +: 2];
  assign sel            = pafs_decode(cur.addr);

  // bus slave, register file and pin routing
  always_comb
  begin
    next_cur       = cur;
    next_cur.hresp = 1'b0;
    unique case (cur.phase)
      // address phase: take the request while ready
      PAFS_BUS_IDLE:
      begin
        next_cur.hreadyout = 1'b1;
        if (hsel_in && htrans_in[1] && hready_in)
        begin
          next_cur.addr      = haddr_in;
          next_cur.write     = hwrite_in;
          next_cur.hreadyout = 1'b0;
          next_cur.phase     = PAFS_BUS_WAIT;
        end
      end

      // data phase: store the write or load the read word
      PAFS_BUS_WAIT:
      begin
        next_cur.hreadyout = 1'b1;
        next_cur.phase     = PAFS_BUS_IDLE;
        next_cur.hrdata    = 32'h0000_0000;
        if (cur.write)
        begin
          // status and unmapped words ignore writes
          unique case (sel)
            PAFS_SEL_UART:
              next_cur.uart_cfg = hwdata_in[7:0];
            PAFS_SEL_LCD:
              next_cur.lcd_ctrl = hwdata_in[7:0];
            PAFS_SEL_P9SEL:
              next_cur.p9sel = hwdata_in[7:0];
            PAFS_SEL_SEGEN:
              next_cur.seg_en = hwdata_in[30:0];
            PAFS_SEL_LCDPIN:
              next_cur.lcd_pin_en = hwdata_in[2:0];
            PAFS_SEL_MISC:
              next_cur.misc = hwdata_in[1:0];
            PAFS_SEL_STATUS,
            PAFS_SEL_NONE:
              next_cur.write = 1'b1;
          endcase
        end
        else
        begin
          // unused upper bits read as zero
          unique case (sel)
            PAFS_SEL_UART:
              next_cur.hrdata = {24'h00_0000, cur.uart_cfg};
            PAFS_SEL_LCD:
              next_cur.hrdata = {24'h00_0000, cur.lcd_ctrl};
            PAFS_SEL_P9SEL:
              next_cur.hrdata = {24'h00_0000, cur.p9sel};
            PAFS_SEL_SEGEN:
              next_cur.hrdata = {1'b0, cur.seg_en};
            PAFS_SEL_LCDPIN:
              next_cur.hrdata = {29'h0000_0000, cur.lcd_pin_en};
            PAFS_SEL_MISC:
              next_cur.hrdata = {30'h0000_0000, cur.misc};
            PAFS_SEL_STATUS:
              next_cur.hrdata = {26'h000_0000, cur.pll_level, pps_second};
            PAFS_SEL_NONE:
              next_cur.hrdata = 32'h0000_0000;
          endcase
        end
      end
    endcase

    // 1 s wide pll pulse, toggles on each pll counter second
    if (pll_second_tick_in)
      next_cur.pll_level = !cur.pll_level;

    // default: port logic owns every pin
    next_cur.pin_out = gpio_out_in;
    next_cur.pin_oe  = gpio_oe_in;

    // serial-one bidirectional data line
    if (cur.uart_cfg[UART_EN_BIT])
    begin
      next_cur.pin_out[PIN_P10_0] = enhanced_serial_port_one_data_line_tx_in;
      next_cur.pin_oe[PIN_P10_0]  = enhanced_serial_port_one_data_line_oe_in;
    end

    // 9.7 card clock pulse
    if (cur.p9sel[P9SEL_PWM_BIT])
    begin
      next_cur.pin_out[PIN_P9_7] = card_clock_pulse_in;
      next_cur.pin_oe[PIN_P9_7]  = 1'b1;
    end

    // 9.6 path-one energy pulse
    if (cur.p9sel[P9SEL_ONE_BIT])
    begin
      next_cur.pin_out[PIN_P9_6] = energy_pulse_path_one_in;
      next_cur.pin_oe[PIN_P9_6]  = 1'b1;
    end

    // 9.5 path-two energy pulse
    if (cur.p9sel[P9SEL_TWO_BIT])
    begin
      next_cur.pin_out[PIN_P9_5] = energy_pulse_path_two_in;
      next_cur.pin_oe[PIN_P9_5]  = 1'b1;
    end

    // 9.4 second pulse, calibrated pattern when enabled
    if (cur.p9sel[P9SEL_PPS_BIT])
    begin
      next_cur.pin_out[PIN_P9_4] = pps_pulse;
      next_cur.pin_oe[PIN_P9_4]  = 1'b1;
    end

    // 9.3 divided pll pulse or 1 s wide level
    if (cur.p9sel[P9SEL_PLL_BIT])
    begin
      next_cur.pin_out[PIN_P9_3] = cur.misc[MISC_PLL1S_BIT] ?
                                   cur.pll_level :
                                   divided_pll_pulse_in;
      next_cur.pin_oe[PIN_P9_3]  = 1'b1;
    end

    // dedicated path-one energy pulse pin
    next_cur.path_one_out = energy_pulse_path_one_in;

    // port 3 backplanes
    if (cur.lcd_pin_en[LCDPIN_P3_BIT])
    begin
      for (int k = 0; k < P3_COM_LINES; k++)
      begin
        next_cur.pin_out[PIN_P3_0 + k] = lcd_backplane_lines_in[k];
        next_cur.pin_oe[PIN_P3_0 + k]  = 1'b1;
      end
    end

    // pins 4.0/4.1 and 5.0/5.1 follow the lcd type
    for (int k = 0; k < PAIR_LINES; k++)
    begin
      if (cur.lcd_pin_en[LCDPIN_P4_BIT])
      begin
        next_cur.pin_out[PIN_P4_0 + k] =
          pafs_is_com(lcd_type_field, LCD_COM_P4_MIN) ?
          lcd_backplane_lines_in[COM_P4_BASE + k] :
          lcd_segment_line_in[k];
        next_cur.pin_oe[PIN_P4_0 + k] = 1'b1;
      end
      if (cur.lcd_pin_en[LCDPIN_P5_BIT])
      begin
        next_cur.pin_out[PIN_P5_0 + k] =
          pafs_is_com(lcd_type_field, LCD_COM_P5_MIN) ?
          lcd_backplane_lines_in[COM_P5_BASE + k] :
          lcd_segment_line_in[SEG_P5_BASE + k];
        next_cur.pin_oe[PIN_P5_0 + k] = 1'b1;
      end
    end

    // individually enabled segment pins
    for (int i = PIN_P4_2; i <= PIN_P4_7; i++)
    begin
      if (cur.seg_en[i - SEGEN_OFS_LO])
      begin
        next_cur.pin_out[i] = lcd_segment_line_in[i - SEG_OFS];
        next_cur.pin_oe[i]  = 1'b1;
      end
    end

    // then 5.2 to 8.2 on the upper enable bits
    for (int i = PIN_P5_2; i <= PIN_P8_2; i++)
    begin
      if (cur.seg_en[i - SEGEN_OFS_HI])
      begin
        next_cur.pin_out[i] = lcd_segment_line_in[i - SEG_OFS];
        next_cur.pin_oe[i]  = 1'b1;
      end
    end
  end

  // state register, everything selects gpio after reset
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      cur            <= '0;
      cur.hreadyout  <= 1'b1;
      cur.uart_cfg   <= RESET_REG8;
      cur.lcd_ctrl   <= RESET_REG8;
      cur.p9sel      <= RESET_REG8;
      cur.seg_en     <= RESET_SEGEN;
      cur.lcd_pin_en <= RESET_LCDPIN;
      cur.misc       <= RESET_MISC;
    end
    else
      cur <= next_cur;
  end

  // bus answer straight from the state flops
  assign hreadyout_out                  = cur.hreadyout;
  assign hrdata_out                     = cur.hrdata;
  assign hresp_out                      = cur.hresp;

  // pin drivers and the dedicated pulse pin
  assign pin_out                        = cur.pin_out;
  assign pin_oe_out                     = cur.pin_oe;
  assign energy_pulse_path_one_out      = cur.path_one_out;

  // register copies for the function engines
  assign enhanced_serial_one_config_out = cur.uart_cfg;
  assign lcd_control_reg_out            = cur.lcd_ctrl;

  // synchronised pin levels back to the port logic
  assign pin_level_out                  = pin_level;
  assign enhanced_serial_port_one_data_line_rx_out     = pin_level[PIN_P10_0];

endmodule // pafs_top

// File: test/pafs_pin_model.sv
`timescale 1ns/1ns
module pafs_pin_model
  import pafs_pkg::*;
(
  input  wire logic [NPIN-1:0] dev_out_in,
  input  wire logic [NPIN-1:0] dev_oe_in,
  input  wire logic [NPIN-1:0] ext_en_in,
  input  wire logic [NPIN-1:0] ext_val_in,
  output logic      [NPIN-1:0] wire_out
);
  // wire level: device first, then outside driver, else weak pull-up
  always_comb
  begin
    for (int i = 0; i < NPIN; i++)
    begin
      if (dev_oe_in[i])
        wire_out[i] = dev_out_in[i];
      else if (ext_en_in[i])
        wire_out[i] = ext_val_in[i];
      else
        wire_out[i] = 1'b1;
    end
  end
endmodule // pafs_pin_model

// File: test/pafs_top_assertions.sv
`timescale 1ns/1ns
module pafs_top_checker
  import pafs_pkg::*;
(
  input wire logic            clk_in,
  input wire logic            reset_n_in,
  input wire logic            hsel_in,
  input wire logic [31:0]     haddr_in,
  input wire logic [1:0]      htrans_in,
  input wire logic            hwrite_in,
  input wire logic [31:0]     hwdata_in,
  input wire logic            hready_in,
  input wire logic            hreadyout_out,
  input wire logic [31:0]     hrdata_out,
  input wire logic            hresp_out,
  input wire logic [NPIN-1:0] gpio_out_in,
  input wire logic [NPIN-1:0] gpio_oe_in,
  input wire logic [NPIN-1:0] pin_level_out,
  input wire logic            enhanced_serial_port_one_data_line_tx_in,
  input wire logic            enhanced_serial_port_one_data_line_oe_in,
  input wire logic            enhanced_serial_port_one_data_line_rx_out,
  input wire logic            energy_pulse_path_one_in,
  input wire logic            energy_pulse_path_one_out,
  input wire logic [7:0]      enhanced_serial_one_config_out,
  input wire logic [7:0]      lcd_control_reg_out,
  input wire logic [NPIN-1:0] pin_in,
  input wire logic [NPIN-1:0] pin_out,
  input wire logic [NPIN-1:0] pin_oe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // accepted bus request and short register names
  wire       req = hsel_in & htrans_in[1] & hready_in & hreadyout_out;
  wire [7:0] cfg = enhanced_serial_one_config_out;
  wire [7:0] lcd = lcd_control_reg_out;

  uart_alt_a: assert property (
    cfg[0] |=> pin_out[0] == $past(enhanced_serial_port_one_data_line_tx_in) &&
      pin_oe_out[0] == $past(enhanced_serial_port_one_data_line_oe_in))
    else $error("serial pin not routed");
  gpio_follow_a: assert property (
    !cfg[0] |=> pin_out[0] == $past(gpio_out_in[0]) &&
      pin_oe_out[0] == $past(gpio_oe_in[0]))
    else $error("pin 0 not general port");
  rx_sync_a: assert property (
    $past(reset_n_in) && $past(reset_n_in, 2) |->
      enhanced_serial_port_one_data_line_rx_out == $past(pin_in[0], 2) &&
      pin_level_out == $past(pin_in, 2))
    else $error("input sampling wrong");
  reset_clear_a: assert property (
    $rose(reset_n_in) |-> cfg == 8'h00 && lcd == 8'h00 && pin_oe_out == '0)
    else $error("state not clear after reset");
  pulse_copy_a: assert property (
    $past(reset_n_in) |->
      energy_pulse_path_one_out == $past(energy_pulse_path_one_in))
    else $error("dedicated pulse pin wrong");
  cfg_write_a: assert property (
    req && hwrite_in && haddr_in == 32'h0000_A814 ##1 1'b1 |=>
      cfg == $past(hwdata_in[7:0]))
    else $error("serial config not stored");
  lcd_write_a: assert property (
    req && hwrite_in && haddr_in == 32'h0000_B078 ##1 1'b1 |=>
      lcd == $past(hwdata_in[7:0]))
    else $error("lcd control not stored");
  bus_wait_a: assert property (
    req |=> !hreadyout_out ##1 hreadyout_out)
    else $error("bus wait wrong");
  rdata_hold_a: assert property (
    hreadyout_out && !req |=> $stable(hrdata_out))
    else $error("read data moved");
  okay_resp_a: assert property (hresp_out == 1'b0)
    else $error("response not okay");

  // main scenarios reached
  cover property (cfg[0] && pin_oe_out[0]);
  cover property (lcd[5:4] == 2'h3);
  cover property (pin_oe_out[PIN_P9_7] && pin_oe_out[PIN_P9_4]);
endmodule // pafs_top_checker

bind pafs_top pafs_top_checker u_chk (.clk_in, .reset_n_in, .hsel_in,
  .haddr_in, .htrans_in, .hwrite_in, .hwdata_in, .hready_in,
  .hreadyout_out, .hrdata_out, .hresp_out, .gpio_out_in, .gpio_oe_in,
  .pin_level_out, .enhanced_serial_port_one_data_line_tx_in, .enhanced_serial_port_one_data_line_oe_in,
  .enhanced_serial_port_one_data_line_rx_out, .energy_pulse_path_one_in,
  .energy_pulse_path_one_out, .enhanced_serial_one_config_out,
  .lcd_control_reg_out, .pin_in, .pin_out, .pin_oe_out);

// File: test/pafs_top_tb.sv
`timescale 1ns/1ns
module pafs_top_tb
  import pafs_pkg::*;
;
  logic            clk_in = 1'b0;
  logic            reset_n_in, hsel_in, hwrite_in, hready_in;
  logic            hreadyout_out, hresp_out;
  logic [1:0]      htrans_in;
  logic [2:0]      hsize_in;
  logic [31:0]     haddr_in, hwdata_in, hrdata_out;
  logic [NPIN-1:0] gpio_out_in, gpio_oe_in, pin_level_out, pin_in;
  logic [NPIN-1:0] pin_out, pin_oe_out, ext_en, ext_val;
  logic            enhanced_serial_port_one_data_line_tx_in, enhanced_serial_port_one_data_line_oe_in;
  logic            enhanced_serial_port_one_data_line_rx_out, card_clock_pulse_in;
  logic            energy_pulse_path_one_in, energy_pulse_path_two_in;
  logic            energy_pulse_path_one_out, divided_pll_pulse_in;
  logic            pps_uncal_pulse_in, pps_cal_pulse_in, pll_second_tick_in;
  logic [NCOM-1:0] lcd_backplane_lines_in;
  logic [NSEG-1:0] lcd_segment_line_in;
  logic [7:0]      enhanced_serial_one_config_out, lcd_control_reg_out;
  int              n_mismatch = 0, num_checks = 0, cyc = 0;

  // single slave: its ready is the bus ready
  assign hready_in = hreadyout_out;

  pafs_top DUT (.clk_in, .reset_n_in, .hsel_in, .haddr_in, .htrans_in,
    .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hreadyout_out,
    .hrdata_out, .hresp_out, .gpio_out_in, .gpio_oe_in, .pin_level_out,
    .enhanced_serial_port_one_data_line_tx_in, .enhanced_serial_port_one_data_line_oe_in,
    .enhanced_serial_port_one_data_line_rx_out, .card_clock_pulse_in,
    .energy_pulse_path_one_in, .energy_pulse_path_two_in,
    .pps_uncal_pulse_in, .pps_cal_pulse_in, .divided_pll_pulse_in,
    .pll_second_tick_in, .lcd_backplane_lines_in, .lcd_segment_line_in,
    .enhanced_serial_one_config_out, .lcd_control_reg_out, .pin_in,
    .pin_out, .pin_oe_out, .energy_pulse_path_one_out);

  pafs_pin_model PINS (.dev_out_in(pin_out), .dev_oe_in(pin_oe_out),
    .ext_en_in(ext_en), .ext_val_in(ext_val), .wire_out(pin_in));

  // compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // one single-word transfer, address phase then data phase
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    haddr_in  <= a;
    hwrite_in <= w;
    htrans_in <= 2'b10;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    htrans_in <= 2'b00;
    hwdata_in <= d;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    r = hrdata_out;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(r, e);
  endtask

  task automatic t_reset();
    logic [31:0] adr [9] = '{32'h0000_A814, 32'h0000_B078, 32'h0000_02B4,
      32'h0000_B100, 32'h0000_B104, 32'h0000_B108, 32'h0000_B10C,
      32'h0000_B110, 32'h0000_B07A};
    for (int i = 0; i < 9; i++)
      rd(adr[i], 32'h0000_0000);
    wr(32'h0000_B110, 32'hFFFF_FFFF);
    wr(32'h0000_B10C, 32'hFFFF_FFFF);
    rd(32'h0000_B110, 32'h0000_0000);
    rd(32'h0000_B10C, 32'h0000_0000);
    chk(pin_oe_out, gpio_oe_in);
    chk(pin_out, gpio_out_in);
    gpio_oe_in <= '0;
  endtask

  task automatic t_uart();
    wr(32'h0000_A814, 32'h0000_0001);
    rd(32'h0000_A814, 32'h0000_0001);
    enhanced_serial_port_one_data_line_oe_in <= 1'b1;
    tick(2);
    chk({pin_oe_out[0], pin_out[0]}, 2'b10);
    enhanced_serial_port_one_data_line_oe_in <= 1'b0;
    ext_en[0] <= 1'b1;
    for (int v = 0; v < 2; v++)
    begin
      ext_val[0] <= v[0];
      tick(4);
      chk({enhanced_serial_port_one_data_line_rx_out, pin_level_out[0]}, {2{v[0]}});
    end
    wr(32'h0000_A814, 32'h0000_0000);
    tick(2);
    chk({pin_oe_out[0], pin_out[0]}, 2'b01);
    ext_en[0] <= 1'b0;
  endtask

  task automatic t_port9();
    wr(32'h0000_02B4, 32'h0000_00FF);
    rd(32'h0000_02B4, 32'h0000_00FF);
    for (int v = 0; v < 2; v++)
    begin
      card_clock_pulse_in      <= v[0];
      energy_pulse_path_one_in <= v[0];
      energy_pulse_path_two_in <= !v[0];
      divided_pll_pulse_in     <= v[0];
      tick(2);
      chk(pin_oe_out[5:1], 5'h1F);
      chk(pin_out[PIN_P9_7], v[0]);
      chk(pin_out[4:3], {v[0], !v[0]});
      chk(energy_pulse_path_one_out, v[0]);
      chk(pin_out[PIN_P9_3], v[0]);
    end
    wr(32'h0000_B108, 32'h0000_0001);
    for (int v = 1; v >= 0; v--)
    begin
      pll_second_tick_in <= 1'b1;
      tick(1);
      pll_second_tick_in <= 1'b0;
      tick(3);
      chk(pin_out[PIN_P9_3], v[0]);
      rd(32'h0000_B10C, {26'h000_0000, v[0], 5'h00});
    end
  endtask

  // one second pulse in, report whether the pin showed it
  task automatic pps(input logic cal, output logic seen);
    if (cal)
      pps_cal_pulse_in <= 1'b1;
    else
      pps_uncal_pulse_in <= 1'b1;
    tick(1);
    pps_cal_pulse_in   <= 1'b0;
    pps_uncal_pulse_in <= 1'b0;
    seen = 1'b0;
    repeat (5)
    begin
      @(posedge clk_in);
      seen |= pin_out[PIN_P9_4];
    end
  endtask

  task automatic t_pps();
    logic seen;
    wr(32'h0000_B108, 32'h0000_0002);
    for (int k = 0; k < 30; k++)
    begin
      pps(1'b0, seen);
      chk(seen, k < 29);
    end
    rd(32'h0000_B10C, 32'h0000_001D);
    pps(1'b1, seen);
    chk(seen, 1'b1);
    pps(1'b0, seen);
    chk(seen, 1'b1);
  endtask

  task automatic t_lcd();
    logic [1:0] p4, p5;
    wr(32'h0000_B104, 32'h0000_0007);
    wr(32'h0000_B100, 32'h4000_0001);
    for (int t = 0; t < 4; t++)
    begin
      wr(32'h0000_B078, 32'(t << 4));
      tick(2);
      p4 = (t != 0) ? lcd_backplane_lines_in[5:4] : lcd_segment_line_in[1:0];
      p5 = (t >= 2) ? lcd_backplane_lines_in[7:6] : lcd_segment_line_in[9:8];
      chk(pin_out[PIN_P4_0 +: 2], p4);
      chk(pin_out[PIN_P5_0 +: 2], p5);
      chk(pin_out[PIN_P3_0 +: 4], lcd_backplane_lines_in[3:0]);
    end
    chk(pin_oe_out[19:6], 14'h307F);
    chk({pin_oe_out[44:43], pin_out[44], pin_out[12]},
        {2'b10, lcd_segment_line_in[34], lcd_segment_line_in[2]});
    reset_n_in <= 1'b0;
    tick(2);
    reset_n_in <= 1'b1;
    rd(32'h0000_B078, 32'h0000_0000);
    rd(32'h0000_B104, 32'h0000_0000);
  endtask

  // free-running clock
  initial
  begin
    forever #20 clk_in = ~clk_in;
  end

  // cycle ceiling
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  // time-zero values, reset, scenarios
  initial
  begin
    {reset_n_in, hwrite_in, htrans_in, haddr_in, hwdata_in} = '0;
    {enhanced_serial_port_one_data_line_tx_in, enhanced_serial_port_one_data_line_oe_in} = '0;
    {card_clock_pulse_in, energy_pulse_path_one_in} = '0;
    {energy_pulse_path_two_in, divided_pll_pulse_in} = '0;
    {pps_uncal_pulse_in, pps_cal_pulse_in, pll_second_tick_in} = '0;
    {ext_en, ext_val} = '0;
    hsel_in = 1'b1;
    hsize_in = 3'b010;
    gpio_out_in = '1;
    gpio_oe_in = {15{3'b101}};
    lcd_backplane_lines_in = 8'hA5;
    lcd_segment_line_in = {1'b1, {17{2'b01}}};
    tick(4);
    reset_n_in <= 1'b1;
    t_reset();
    t_uart();
    t_port9();
    t_pps();
    t_lcd();
    final_report();
  end
endmodule // pafs_top_tb
